//--- design/sbt_pkg.sv
// shared constants for the serial bcd timekeeper and its host controller
// assumes both ends run on one 10 MHz system clock
package sbt_pkg;
    // register indices on the link
    localparam logic [2:0] REG_SECONDS = 3'h0;
    localparam logic [2:0] REG_MINUTES = 3'h1;
    localparam logic [2:0] REG_HOURS = 3'h2;
    localparam logic [2:0] REG_DATE = 3'h3;
    localparam logic [2:0] REG_MONTH = 3'h4;
    localparam logic [2:0] REG_WEEKDAY = 3'h5;
    localparam logic [2:0] REG_YEAR = 3'h6;
    localparam logic [2:0] REG_LOCK = 3'h7;
    // field positions
    localparam int HALT_BIT = 7;
    localparam int FORMAT_BIT = 7;
    localparam int MERIDIEM_BIT = 5;
    localparam int LOCK_BIT = 7;
    localparam int DIR_BIT = 0;
    localparam int MARK_BIT = 7;
    // implemented bits and reset values, register 7 first
    localparam logic [7:0][7:0] REG_MASK = {8'h80, 8'hFF, 8'h07, 8'h1F,
                                            8'h3F, 8'hBF, 8'h7F, 8'hFF};
    localparam logic [7:0][7:0] REG_RESET = {8'h80, 8'h00, 8'h01, 8'h01,
                                             8'h01, 8'h00, 8'h00, 8'h80};
    // command codes
    localparam logic [5:0] CMD_BURST_FIELD = 6'h1F;
    localparam logic [3:0] CMD_TEST_PREFIX = 4'h9;
    localparam logic [2:0] CMD_SINGLE_HIGH = 3'h0;
    localparam int SINGLE_BITS = 16;
    localparam int BURST_BITS = 72;
    // timing
    localparam int OSC_DIV_DEFAULT = 32768;
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_SCLK_HALF_NS = 1000;
    localparam int T_GATE_SETUP_NS = 4000;
    localparam int T_GATE_IDLE_NS = 4000;
    localparam int SCLK_HALF_CYC =
        (T_SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GATE_SETUP_CYC =
        (T_GATE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GATE_IDLE_CYC =
        (T_GATE_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // host controller register offsets
    localparam logic [3:0] HOST_CMD = 4'h0;
    localparam logic [3:0] HOST_STATUS = 4'h1;
    localparam logic [3:0] HOST_DATA0 = 4'h2;
    localparam logic [3:0] HOST_DATA7 = 4'h9;

    typedef enum logic [1:0] {
        D_IDLE = 2'b00, D_CMD = 2'b01, D_XFER = 2'b11, D_DONE = 2'b10
    } sbt_dev_state_e;
    typedef enum logic [1:0] {
        H_IDLE = 2'b00, H_SETUP = 2'b01, H_SHIFT = 2'b11, H_END = 2'b10
    } sbt_host_state_e;
endpackage : sbt_pkg

//--- design/sbt_link_if.sv
// three-wire link between host controller and timekeeper
// the data wire has a pull-up: it reads high when nobody drives it
`timescale 1ns/100ps
interface sbt_link_if;
    logic transfer_gate;
    logic shift_clock;
    logic host_data_out;
    logic host_data_oe;
    logic dev_data_out;
    logic dev_data_oe;
    logic data_level;

    assign data_level = dev_data_oe ? dev_data_out :
                        host_data_oe ? host_data_out : 1'b1;

    modport device(input transfer_gate, input shift_clock,
                   input data_level,
                   output dev_data_out, output dev_data_oe);
    modport host(output transfer_gate, output shift_clock,
                 output host_data_out, output host_data_oe,
                 input data_level);
endinterface : sbt_link_if

//--- design/sbt_calendar.sv
// bcd clock and calendar register bank with one-second prescaler
// assumes i_osc_rise is a one-cycle pulse per rising oscillator edge
`timescale 1ns/100ps
module sbt_calendar
    import sbt_pkg::*;
#(
    parameter int unsigned OSC_DIV = OSC_DIV_DEFAULT
) (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_osc_rise,
    input wire logic i_wr_en,
    input wire logic [2:0] i_wr_idx,
    input wire logic [7:0] i_wr_data,
    output logic [7:0][7:0] o_regs
);
    logic [7:0][7:0] regs_ff;
    logic [7:0][7:0] nxt_regs;
    logic [15:0] pre_ff;
    logic tick;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    // last day of the month; every fourth year is a leap year
    function automatic logic [7:0] month_end(input logic [7:0] m,
                                             input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
               (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m[4:0])
            5'h02: month_end = leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: month_end = 8'h30;
            default: month_end = 8'h31;
        endcase
    endfunction : month_end

    // halt freezes the prescaler so the second phase is kept
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pre_ff <= 16'h0000;
        end else if (!regs_ff[REG_SECONDS][HALT_BIT] && i_osc_rise) begin
            if (pre_ff == 16'(OSC_DIV - 1)) begin
                pre_ff <= 16'h0000;
            end else begin
                pre_ff <= pre_ff + 16'h0001;
            end
        end
    end

    assign tick = !regs_ff[REG_SECONDS][HALT_BIT] && i_osc_rise &&
                  pre_ff == 16'(OSC_DIV - 1);

    always_comb begin
        logic c;
        logic pm;
        logic [7:0] h;
        logic [7:0] t;
        c = 1'b0;
        pm = 1'b0;
        h = 8'h00;
        t = 8'h00;
        nxt_regs = regs_ff;
        if (tick) begin
            c = regs_ff[REG_SECONDS][6:0] == 7'h59;
            t = bcd_inc({1'b0, regs_ff[REG_SECONDS][6:0]});
            nxt_regs[REG_SECONDS][6:0] = c ? 7'h00 : t[6:0];
            if (c) begin
                c = regs_ff[REG_MINUTES] == 8'h59;
                nxt_regs[REG_MINUTES] = c ? 8'h00 :
                    bcd_inc(regs_ff[REG_MINUTES]);
            end
            if (c) begin
                h = regs_ff[REG_HOURS];
                if (h[FORMAT_BIT]) begin
                    pm = h[MERIDIEM_BIT];
                    c = 1'b0;
                    if (h[4:0] == 5'h12) begin
                        h[4:0] = 5'h01;
                    end else if (h[4:0] == 5'h11) begin
                        h[4:0] = 5'h12;
                        h[MERIDIEM_BIT] = !pm;
                        c = pm;
                    end else begin
                        t = bcd_inc({3'b000, h[4:0]});
                        h[4:0] = t[4:0];
                    end
                end else begin
                    c = h[5:0] == 6'h23;
                    t = bcd_inc({2'b00, h[5:0]});
                    h[5:0] = c ? 6'h00 : t[5:0];
                end
                nxt_regs[REG_HOURS] = h;
            end
            if (c) begin
                nxt_regs[REG_WEEKDAY] = regs_ff[REG_WEEKDAY] == 8'h07 ?
                    8'h01 : bcd_inc(regs_ff[REG_WEEKDAY]);
                c = regs_ff[REG_DATE] ==
                    month_end(regs_ff[REG_MONTH], regs_ff[REG_YEAR]);
                nxt_regs[REG_DATE] = c ? 8'h01 : bcd_inc(regs_ff[REG_DATE]);
            end
            if (c) begin
                c = regs_ff[REG_MONTH] == 8'h12;
                nxt_regs[REG_MONTH] = c ? 8'h01 :
                    bcd_inc(regs_ff[REG_MONTH]);
            end
            if (c) begin
                nxt_regs[REG_YEAR] = regs_ff[REG_YEAR] == 8'h99 ? 8'h00 :
                    bcd_inc(regs_ff[REG_YEAR]);
            end
        end
        // a write overrides the tick for its own register only
        if (i_wr_en) begin
            nxt_regs[i_wr_idx] = i_wr_data & REG_MASK[i_wr_idx];
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            regs_ff <= REG_RESET;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    assign o_regs = regs_ff;
endmodule : sbt_calendar

//--- design/sbt_device.sv
// timekeeper end of the three-wire link
// assumes the gate, shift clock, data and oscillator are asynchronous
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module sbt_device
    import sbt_pkg::*;
#(
    parameter int unsigned OSC_DIV = OSC_DIV_DEFAULT
) (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_osc_clock,
    sbt_link_if.device link,
    output logic o_oscillator_halt
);
    // bit 0 gate, 1 shift clock, 2 data, 3 oscillator
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic sclk_d_ff;
    logic osc_d_ff;
    logic gate;
    logic din;
    logic rise;
    logic fall;
    logic osc_rise;

    sbt_dev_state_e state_ff;
    logic [2:0] bit_ff;
    logic [2:0] byte_ff;
    logic [7:0] cmd_ff;
    logic [7:0] data_ff;
    logic is_read_ff;
    logic is_burst_ff;
    logic out_ff;
    logic oe_ff;
    logic wr_en_ff;
    logic [2:0] wr_idx_ff;
    logic [7:0] wr_data_ff;

    logic [7:0] cmd_full;
    logic [7:0] data_full;
    logic [7:0][7:0] regs;
    logic locked;
    logic wr_allowed;

    function automatic logic is_burst(input logic [7:0] c);
        is_burst = c[6:1] == CMD_BURST_FIELD;
    endfunction : is_burst

    // anything but a register or burst code is dropped, test code too
    function automatic logic cmd_ok(input logic [7:0] c);
        logic test;
        test = c[7:4] == CMD_TEST_PREFIX && c[0];
        cmd_ok = c[MARK_BIT] && !test &&
                 (c[6:4] == CMD_SINGLE_HIGH || is_burst(c));
    endfunction : cmd_ok

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
        end else begin
            sync1_ff <= {i_osc_clock, link.data_level, link.shift_clock,
                         link.transfer_gate};
            sync2_ff <= sync1_ff;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sclk_d_ff <= 1'b0;
            osc_d_ff <= 1'b0;
        end else begin
            sclk_d_ff <= sync2_ff[1];
            osc_d_ff <= sync2_ff[3];
        end
    end

    assign gate = sync2_ff[0];
    assign din = sync2_ff[2];
    assign rise = gate && sync2_ff[1] && !sclk_d_ff;
    assign fall = gate && !sync2_ff[1] && sclk_d_ff;
    assign osc_rise = sync2_ff[3] && !osc_d_ff;
    assign cmd_full = {din, cmd_ff[7:1]};
    assign data_full = {din, data_ff[7:1]};
    assign locked = regs[REG_LOCK][LOCK_BIT];

    // lock register itself stays writable by single-byte writes so software can unlock; a burst never writes it
    always_comb begin
        if (is_burst_ff) begin
            wr_allowed = !locked && byte_ff != REG_LOCK;
        end else begin
            wr_allowed = !locked || byte_ff == REG_LOCK;
        end
    end

    // transfer sequencer
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff <= D_IDLE;
            bit_ff <= 3'h0;
            byte_ff <= 3'h0;
            cmd_ff <= 8'h00;
            data_ff <= 8'h00;
            is_read_ff <= 1'b0;
            is_burst_ff <= 1'b0;
        end else if (!gate) begin
            state_ff <= D_IDLE;
            bit_ff <= 3'h0;
        end else begin
            case (state_ff)
                D_IDLE: begin
                    state_ff <= D_CMD;
                    bit_ff <= 3'h0;
                end
                D_CMD: begin
                    if (rise) begin
                        cmd_ff <= cmd_full;
                        bit_ff <= bit_ff + 3'h1;
                        if (bit_ff == 3'h7) begin
                            is_read_ff <= cmd_full[DIR_BIT];
                            is_burst_ff <= is_burst(cmd_full);
                            byte_ff <= is_burst(cmd_full) ? REG_SECONDS :
                                       cmd_full[3:1];
                            state_ff <= cmd_ok(cmd_full) ? D_XFER : D_DONE;
                        end
                    end
                end
                D_XFER: begin
                    if (!is_read_ff && rise) begin
                        data_ff <= data_full;
                        bit_ff <= bit_ff + 3'h1;
                        if (bit_ff == 3'h7) begin
                            byte_ff <= byte_ff + 3'h1;
                            if (!is_burst_ff || byte_ff == REG_LOCK) begin
                                state_ff <= D_DONE;
                            end
                        end
                    end else if (is_read_ff && fall) begin
                        bit_ff <= bit_ff + 3'h1;
                        if (bit_ff == 3'h7 && is_burst_ff) begin
                            byte_ff <= byte_ff + 3'h1;
                        end
                    end
                end
                D_DONE: begin
                    state_ff <= D_DONE;
                end
                default: begin
                    state_ff <= D_IDLE;
                end
            endcase
        end
    end

    // one write strobe per completed write data byte that the lock allows
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_en_ff <= 1'b0;
            wr_idx_ff <= 3'h0;
            wr_data_ff <= 8'h00;
        end else begin
            wr_en_ff <= gate && state_ff == D_XFER && !is_read_ff &&
                        rise && bit_ff == 3'h7 && wr_allowed;
            wr_idx_ff <= byte_ff;
            wr_data_ff <= data_full;
        end
    end

    // read data from live registers; a byte may straddle a second tick
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else if (!gate) begin
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else if (state_ff == D_XFER && is_read_ff && fall) begin
            out_ff <= regs[byte_ff][bit_ff];
            oe_ff <= 1'b1;
        end
    end

    sbt_calendar #(
        .OSC_DIV(OSC_DIV)
    ) u_calendar (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_osc_rise(osc_rise),
        .i_wr_en(wr_en_ff),
        .i_wr_idx(wr_idx_ff),
        .i_wr_data(wr_data_ff),
        .o_regs(regs)
    );

    assign link.dev_data_out = out_ff;
    assign link.dev_data_oe = oe_ff;
    assign o_oscillator_halt = regs[REG_SECONDS][HALT_BIT];
endmodule : sbt_device

//--- design/sbt_host.sv
// host controller end of the three-wire link
// software writes a command byte to start; eight data bytes buffered
`timescale 1ns/100ps
module sbt_host
    import sbt_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [7:0] o_rdata,
    sbt_link_if.host link
);
    sbt_host_state_e state_ff;
    logic [7:0] cmd_ff;
    logic [63:0] buf_ff;
    logic [7:0] rdata_ff;
    logic [5:0] cnt_ff;
    logic [4:0] ph_ff;
    logic [6:0] bit_ff;
    logic [6:0] last_ff;
    logic gate_ff;
    logic sclk_ff;
    logic dout_ff;
    logic oe_ff;
    logic din1_ff;
    logic din2_ff;
    logic start;
    logic capture;
    logic rd;
    logic [6:0] nbit;
    logic [5:0] didx;

    assign start = i_write && i_addr == HOST_CMD && state_ff == H_IDLE;
    assign rd = cmd_ff[DIR_BIT];
    assign nbit = bit_ff + 7'h01;
    assign didx = 6'(bit_ff - 7'd8);
    assign capture = state_ff == H_SHIFT && rd && bit_ff >= 7'd8 &&
                     ph_ff == 5'(SCLK_HALF_CYC - 1);

    function automatic logic tx_bit(input logic [6:0] n,
                                    input logic [7:0] c,
                                    input logic [63:0] b);
        tx_bit = n < 7'd8 ? c[n[2:0]] : b[6'(n - 7'd8)];
    endfunction : tx_bit

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            din1_ff <= 1'b1;
            din2_ff <= 1'b1;
        end else begin
            din1_ff <= link.data_level;
            din2_ff <= din1_ff;
        end
    end

    // software registers and receive buffer
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cmd_ff <= 8'h00;
            buf_ff <= 64'h0;
        end else begin
            if (start) begin
                cmd_ff <= i_wdata;
            end
            if (capture) begin
                buf_ff[didx] <= din2_ff;
            end else if (i_write && i_addr >= HOST_DATA0 &&
                         i_addr <= HOST_DATA7) begin
                buf_ff[8 * 3'(i_addr - HOST_DATA0) +: 8] <= i_wdata;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_ff <= 8'h00;
        end else if (!i_read) begin
            rdata_ff <= 8'h00;
        end else if (i_addr == HOST_CMD) begin
            rdata_ff <= cmd_ff;
        end else if (i_addr == HOST_STATUS) begin
            rdata_ff <= {7'h00, state_ff != H_IDLE};
        end else if (i_addr >= HOST_DATA0 && i_addr <= HOST_DATA7) begin
            rdata_ff <= buf_ff[8 * 3'(i_addr - HOST_DATA0) +: 8];
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // link sequencer: gate setup, bits, gate idle time
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff <= H_IDLE;
            cnt_ff <= 6'h00;
            ph_ff <= 5'h00;
            bit_ff <= 7'h00;
            last_ff <= 7'h00;
            gate_ff <= 1'b0;
            sclk_ff <= 1'b0;
            dout_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            case (state_ff)
                H_IDLE: begin
                    if (start) begin
                        state_ff <= H_SETUP;
                        cnt_ff <= 6'h00;
                        gate_ff <= 1'b1;
                        last_ff <= i_wdata[6:1] == CMD_BURST_FIELD ?
                            7'(BURST_BITS - 1) : 7'(SINGLE_BITS - 1);
                    end
                end
                H_SETUP: begin
                    cnt_ff <= cnt_ff + 6'h01;
                    if (cnt_ff == 6'(GATE_SETUP_CYC - 1)) begin
                        state_ff <= H_SHIFT;
                        ph_ff <= 5'h00;
                        bit_ff <= 7'h00;
                        dout_ff <= cmd_ff[0];
                        oe_ff <= 1'b1;
                    end
                end
                H_SHIFT: begin
                    ph_ff <= ph_ff + 5'h01;
                    if (ph_ff == 5'(SCLK_HALF_CYC - 1)) begin
                        sclk_ff <= 1'b1;
                    end else if (ph_ff == 5'(2 * SCLK_HALF_CYC - 1)) begin
                        sclk_ff <= 1'b0;
                        ph_ff <= 5'h00;
                        if (bit_ff == last_ff) begin
                            state_ff <= H_END;
                            cnt_ff <= 6'h00;
                            oe_ff <= 1'b0;
                        end else begin
                            bit_ff <= nbit;
                            dout_ff <= tx_bit(nbit, cmd_ff, buf_ff);
                            oe_ff <= !(rd && nbit >= 7'd8);
                        end
                    end
                end
                H_END: begin
                    gate_ff <= 1'b0;
                    cnt_ff <= cnt_ff + 6'h01;
                    if (cnt_ff == 6'(GATE_IDLE_CYC - 1)) begin
                        state_ff <= H_IDLE;
                    end
                end
                default: begin
                    state_ff <= H_IDLE;
                end
            endcase
        end
    end

    assign o_rdata = rdata_ff;
    assign link.transfer_gate = gate_ff;
    assign link.shift_clock = sclk_ff;
    assign link.host_data_out = dout_ff;
    assign link.host_data_oe = oe_ff;
endmodule : sbt_host

//--- sim/sbt_link_checker.sv
// link checker: watches the three-wire link between host and timekeeper
// assumes one system clock and one async low reset for both ends
`timescale 1ns/100ps
module sbt_link_checker (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic transfer_gate,
    input wire logic shift_clock,
    input wire logic host_data_out,
    input wire logic host_data_oe,
    input wire logic dev_data_out,
    input wire logic dev_data_oe
);
    logic [6:0] rise_cnt_ff;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    // rising shift clock edges seen inside the current frame
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rise_cnt_ff <= 7'h00;
        end else if (!transfer_gate) begin
            rise_cnt_ff <= 7'h00;
        end else if ($rose(shift_clock)) begin
            rise_cnt_ff <= rise_cnt_ff + 7'h01;
        end
    end
    sequence sclk_high_phase;
        shift_clock[*8] ##1 shift_clock[*2] ##1 !shift_clock;
    endsequence
    AST_HIGH_HALF: assert property ($rose(shift_clock) |->
        sclk_high_phase)
        else $error("shift clock high phase has wrong length");
    AST_FRAME_COUNT: assert property ($fell(transfer_gate) |->
        rise_cnt_ff == 7'h10 || rise_cnt_ff == 7'h48)
        else $error("frame ended with wrong clock count");
    AST_GATE_QUIET: assert property (!transfer_gate |->
        !shift_clock && !host_data_oe)
        else $error("link active outside a frame");
    AST_RELEASE: assert property ($fell(transfer_gate) |->
        ##[0:6] !dev_data_oe)
        else $error("data pin still driven after gate low");
    AST_NO_FIGHT: assert property (!(dev_data_oe && host_data_oe))
        else $error("both ends drive the data wire");
    AST_FIRST_OUT: assert property ($rose(dev_data_oe) |->
        !shift_clock && rise_cnt_ff == 7'h08)
        else $error("device drove data at the wrong moment");
    AST_OUT_ON_LOW: assert property (dev_data_oe &&
        $changed(dev_data_out) |-> !shift_clock)
        else $error("device data changed while shift clock high");
    AST_HOST_HOLD: assert property (host_data_oe && shift_clock |->
        $stable(host_data_out))
        else $error("host data changed around a rising edge");
endmodule : sbt_link_checker

//--- sim/serial_bcd_timekeeper_tb.sv
// self-checking bench: host controller and timekeeper joined by the link
// drives the host register port; oscillator is a free-running 800 ns clock
`timescale 1ns/100ps
module serial_bcd_timekeeper_tb;
    import sbt_pkg::*;
    logic i_clock, i_arst_n, i_osc_clock, i_write, i_read, halt, chk, take;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, got, w;
    logic [7:0] exp_q[$];
    logic [7:0] bytes[8];
    logic [7:0] mask[8] = '{8'hFF, 8'h7F, 8'hBF, 8'h3F, 8'h1F, 8'h07,
                           8'hFF, 8'h80};
    int bad_count, comparisons, seed, k;
    sbt_link_if link_bus();
    sbt_host i_sbt_host(.i_clock(i_clock), .i_arst_n(i_arst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
        .i_read(i_read), .o_rdata(o_rdata), .link(link_bus));
    sbt_device #(.OSC_DIV(4)) i_sbt_device(.i_clock(i_clock),
        .i_arst_n(i_arst_n), .i_osc_clock(i_osc_clock), .link(link_bus),
        .o_oscillator_halt(halt));
    sbt_link_checker i_sbt_link_checker(.i_clock(i_clock),
        .i_arst_n(i_arst_n), .transfer_gate(link_bus.transfer_gate),
        .shift_clock(link_bus.shift_clock),
        .host_data_out(link_bus.host_data_out),
        .host_data_oe(link_bus.host_data_oe),
        .dev_data_out(link_bus.dev_data_out),
        .dev_data_oe(link_bus.dev_data_oe));
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    initial begin
        i_osc_clock = 1'b0;
        #130;
        forever #400 i_osc_clock = ~i_osc_clock;
    end
    task automatic cmp(input string what, input logic [7:0] e,
                       input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask : cmp
    task automatic test_done();
        // an expectation never answered counts against the run
        if (exp_q.size() != 0) begin
            bad_count++;
        end
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    // read data is taken one cycle after the strobe, and only there
    always @(posedge i_clock) begin
        take <= i_read && chk;
        if (take && exp_q.size() > 0) begin
            cmp("read data", exp_q.pop_front(), o_rdata);
        end
    end
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [7:0] d, input logic c);
        @(posedge i_clock);
        i_write <= wr;
        i_read <= !wr;
        i_addr <= a;
        i_wdata <= d;
        chk <= c;
        @(posedge i_clock);
        i_write <= 1'b0;
        i_read <= 1'b0;
        chk <= 1'b0;
        @(negedge i_clock);
        got = o_rdata;
    endtask : bus
    task automatic expect_rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00, 1'b1);
    endtask : expect_rd
    task automatic xfer(input logic [7:0] cmd);
        int n;
        // scenarios never send the reserved test code
        bus(1'b1, HOST_CMD, cmd, 1'b0);
        for (n = 0; n < 1000; n++) begin
            bus(1'b0, HOST_STATUS, 8'h00, 1'b0);
            if (got[0] === 1'b0) break;
        end
        if (n == 1000) begin
            bad_count++;
            test_done();
        end
    endtask : xfer
    task automatic sw(input logic [7:0] cmd, input logic [7:0] d);
        bus(1'b1, HOST_DATA0, d, 1'b0);
        xfer(cmd);
    endtask : sw
    task automatic sr(input logic [7:0] cmd, input logic [7:0] e);
        xfer(cmd);
        expect_rd(HOST_DATA0, e);
    endtask : sr
    function automatic logic [7:0] bcd(input int base, input int span);
        int v;
        v = base + {$random(seed)} % span;
        return 8'((v / 10) * 16 + v % 10);
    endfunction : bcd
    initial begin
        seed = 30693;
        i_arst_n = 1'b0;
        {i_write, i_read, chk} = 3'h0;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        repeat (2) @(posedge i_clock);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_clock);
        sr(8'h8F, 8'h80);
        cmp("halt", 8'h01, {7'h00, halt});
        expect_rd(4'hC, 8'h00);
        sw(8'h8E, 8'h00);
        sw(8'h80, 8'h00);
        cmp("halt", 8'h00, {7'h00, halt});
        sr(8'h8F, 8'h00);
        $display("test reset and unlock done");
        bytes = '{8'h80 | bcd(0, 60), 8'h80 | bcd(0, 60), 8'h40 | bcd(0, 24),
                  8'hC0 | bcd(1, 28), 8'hE0 | bcd(1, 12), 8'hF8 | bcd(1, 7),
                  bcd(0, 100), 8'h80};
        for (k = 0; k < 8; k++) bus(1'b1, HOST_DATA0 + 4'(k), bytes[k], 1'b0);
        xfer(8'hBE);
        cmp("halt", 8'h01, {7'h00, halt});
        xfer(8'hBF);
        for (k = 0; k < 8; k++) begin
            // halt bit reads back; lock bit keeps its unlocked 0
            w = k == 7 ? 8'h00 : bytes[k] & mask[k];
            expect_rd(HOST_DATA0 + 4'(k), w);
        end
        $display("test burst done");
        sw(8'h8E, 8'h80);
        sw(8'h82, 8'h00);
        sr(8'h83, bytes[1] & 8'h7F);
        $display("test lock done");
        w = (bytes[5] & 8'h07) == 8'h07 ? 8'h01 : (bytes[5] & 8'h07) + 8'h01;
        sw(8'h8E, 8'h00);
        sw(8'h02, 8'h00);
        sr(8'h83, bytes[1] & 8'h7F);
        sw(8'h84, 8'hB1);
        sw(8'h82, 8'h59);
        sw(8'h80, 8'h59);
        sr(8'h85, 8'h92);
        sr(8'h8B, w);
        cmp("halt", 8'h00, {7'h00, halt});
        $display("test rollover done");
        @(posedge i_clock);
        #1;
        test_done();
    end
endmodule : serial_bcd_timekeeper_tb
